// file: bench/spc_panel_chk.sv
`timescale 1ns/1ns
module spc_panel_chk import spc_pkg::*; (
   input wire logic CLK_SYS, RESET_N, DIP_LEFT, DIP_RIGHT,
   input wire logic BUILD_UNMODIFIED, NOTE_ON_VALID, NOTE_LEGATO,
   input wire logic USB_MIDI, PORT1_RS232, PORT2_COM_EN, LED_PLUS,
   input wire logic SINGLE_VOICE_STYLE, NOTE_PLAY, DRUM_HIT,
   input wire logic [3:0] NOTE_ON_CH, CHROMATIC_CH, MAX_VOICES,
   input wire logic [DIV_W-1:0] PORT1_BIT_CYC,
   input wire logic [6:0] GLIDE_RATE, VIB_DEPTH,
   input wire logic signed [7:0] VOLUME,
   input wire spc_theme_t THEME
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   logic [1:0] ok;
   // edges seen since reset release, saturating
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) ok <= 2'h0;
      else if (ok != 2'h3) ok <= ok + 2'h1;
   end
   usb_mode_a: assert property (
      ok == 2'h3 && !$past(BUILD_UNMODIFIED, 2)
      |-> USB_MIDI == $past(DIP_LEFT)) else $error("usb mode wrong");
   port_mode_a: assert property (
      ok == 2'h3 |-> PORT1_RS232 ==
      (!$past(BUILD_UNMODIFIED, 2) && $past(DIP_RIGHT)))
      else $error("port1 mode wrong");
   strap_mode_a: assert property (
      ok == 2'h3 && $past(BUILD_UNMODIFIED, 2) |-> PORT2_COM_EN)
      else $error("strap mode wrong");
   bit_rate_a: assert property (PORT1_BIT_CYC ==
      (PORT1_RS232 ? COM_BIT_CYC : MIDI_BIT_CYC)) else $error("rate");
   voice_cnt_a: assert property (MAX_VOICES ==
      (SINGLE_VOICE_STYLE ? VOICES_MONO : VOICES_POLY)) else $error("voices");
   value_range_a: assert property (VOLUME >= VOL_MIN &&
      VOLUME <= VOL_MAX && VIB_DEPTH <= 7'h64) else $error("range");
   plus_theme_a: assert property (LED_PLUS |->
      THEME inside {TH_GENERAL, TH_OSC}) else $error("plus theme");
   drum_prio_a: assert property (DRUM_HIT |->
      $past(NOTE_ON_VALID) && $past(NOTE_ON_CH) != $past(CHROMATIC_CH)
      && !NOTE_PLAY) else $error("drum priority");
   glide_leg_a: assert property (NOTE_PLAY && !$past(NOTE_LEGATO)
      |-> GLIDE_RATE == 7'h00) else $error("glide not legato");
endmodule

// file: bench/spc_panel_tb.sv
`timescale 1ns/1ns
module spc_panel_tb;
   import spc_pkg::*;
   logic CLK_SYS = 1'h0, RESET_N = 1'h0, DIP_LEFT = 1'h0, DIP_RIGHT = 1'h0;
   logic BUILD_UNMODIFIED = 1'h0, PANEL_USB_MIDI = 1'h0, NOTE_LEGATO = 1'h0;
   logic NOTE_ON_VALID = 1'h0, DRUM_CH_WE = 1'h0, turn = 1'h0, up = 1'h0;
   logic [3:0] NOTE_ON_CH = 4'h0, CHROMATIC_CH = 4'h0, DRUM_CH_IN = 4'h0;
   logic [4:0] key = 5'h00;
   wire KEY_UP = key[K_UP], KEY_DOWN = key[K_DOWN], ENC_PUSH = key[K_PUSH];
   wire NEXT_ITEM_KEY = key[K_NEXT], KEY_BACK = key[K_BACK], ENC_A, ENC_B;
   logic USB_MIDI, PORT1_RS232, PORT2_COM_EN, LED_PLUS, PLAY_MODE, EXT_UP;
   logic EXT_STEP, SINGLE_VOICE_STYLE, WOBBLE_FROM_SECOND_OSC, DRUM_HIT;
   logic FLEXIBLE_ROUTING_SET, NOTE_PLAY;
   logic [9:0] PORT1_BIT_CYC;
   spc_theme_t THEME;
   logic [3:0] ITEM, MAX_VOICES, PERCUSSION_PICK;
   logic signed [7:0] VOLUME, FILTER3_PEAK, FILTER4_PEAK;
   logic signed [7:0] DRUM_ALL_LEVEL, DRUM_HIT_LEVEL;
   logic [5:0] SOUND_SET;
   logic [6:0] GLIDE_RATE, VIB_DEPTH, NOTE_ON_KEY = 7'h00;
   logic [2:0] DRUM_ID;
   int n_mismatch = 0, compares = 0, cyc = 0;
   spc_panel_top #(.LONG_PRESS_CYCLES(40), .DEBOUNCE_CYCLES(4)) dut (.*);
   spc_player pl (.clk(CLK_SYS), .turn(turn), .turn_up(up), .enc_a(ENC_A),
      .enc_b(ENC_B));
   task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge CLK_SYS);
   endtask
   task automatic press(int k, int hold);
      @(posedge CLK_SYS) key[k] <= 1'h1;
      tick(hold);
      key[k] <= 1'h0;
      tick(10);
   endtask
   task automatic rot(logic u);
      @(posedge CLK_SYS) turn <= 1'h1;
      up <= u;
      @(posedge CLK_SYS) turn <= 1'h0;
      tick(6);
   endtask
   task automatic note(logic [3:0] ch, logic [6:0] k, logic leg);
      @(posedge CLK_SYS) NOTE_ON_VALID <= 1'h1;
      NOTE_ON_CH <= ch;
      NOTE_ON_KEY <= k;
      NOTE_LEGATO <= leg;
      @(posedge CLK_SYS) NOTE_ON_VALID <= 1'h0;
      #1;
   endtask
   task automatic t_reset;
      chk("theme", 10'(TH_GENERAL), 10'(THEME));
      chk("play", 10'h0, 10'({PLAY_MODE, LED_PLUS, SOUND_SET}));
      chk("volume", 10'(VOL_DEF), 10'(VOLUME));
      chk("voices", 10'(VOICES_POLY), 10'(MAX_VOICES));
      chk("bass", 10'h0, 10'({FLEXIBLE_ROUTING_SET, FILTER3_PEAK}));
      chk("treble", 10'h0, 10'(FILTER4_PEAK));
   endtask
   task automatic t_modes;
      @(posedge CLK_SYS) DIP_LEFT <= 1'h1;
      DIP_RIGHT <= 1'h1;
      tick(3);
      chk("usb", 10'h1, 10'(USB_MIDI));
      chk("rate", COM_BIT_CYC, PORT1_BIT_CYC);
      BUILD_UNMODIFIED <= 1'h1;
      tick(4);
      chk("usb", 10'h0, 10'(USB_MIDI));
      chk("com", 10'h1, 10'(PORT2_COM_EN));
      chk("rate", MIDI_BIT_CYC, PORT1_BIT_CYC);
      BUILD_UNMODIFIED <= 1'h0;
      DIP_RIGHT <= 1'h0;
      tick(4);
      chk("rs232", 10'h0, 10'(PORT1_RS232));
   endtask
   task automatic t_nav;
      press(K_DOWN, 10);
      chk("theme", 10'(TH_SYSTEM), 10'(THEME));
      press(K_UP, 10);
      press(K_UP, 2);
      chk("theme", 10'(TH_GENERAL), 10'(THEME));
      press(K_BACK, 10);
      chk("item", 10'(IT_TREB), 10'(ITEM));
      press(K_NEXT, 10);
      chk("item", 10'(IT_VOL), 10'(ITEM));
      repeat (13) rot(1'h1);
      chk("volume", 10'(VOL_MAX), 10'(VOLUME));
      rot(1'h0);
      chk("volume", 10'h5, 10'(VOLUME));
      repeat (3) press(K_NEXT, 10);
      rot(1'h1);
   endtask
   task automatic t_push;
      press(K_PUSH, 10);
      chk("plus", 10'h1, 10'(LED_PLUS));
      press(K_PUSH, 10);
      chk("plus", 10'h0, 10'(LED_PLUS));
      press(K_PUSH, 60);
      chk("play", 10'h1, 10'(PLAY_MODE));
      press(K_PUSH, 60);
      chk("play", 10'h0, 10'(PLAY_MODE));
   endtask
   task automatic t_notes;
      note(4'h9, 7'h23, 1'h0);
      chk("drum", 10'h10, 10'({DRUM_HIT, NOTE_PLAY, DRUM_ID}));
      note(4'h9, 7'h26, 1'h0);
      chk("drum", 10'h11, 10'({DRUM_HIT, NOTE_PLAY, DRUM_ID}));
      @(posedge CLK_SYS) DRUM_CH_WE <= 1'h1;
      DRUM_CH_IN <= 4'h3;
      @(posedge CLK_SYS) DRUM_CH_WE <= 1'h0;
      note(4'h3, 7'h2A, 1'h0);
      chk("drum", 10'h12, 10'({DRUM_HIT, NOTE_PLAY, DRUM_ID}));
      CHROMATIC_CH <= 4'h3;
      note(4'h3, 7'h24, 1'h0);
      chk("note", 10'h80,
          10'({DRUM_HIT, NOTE_PLAY, GLIDE_RATE}));
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // free-running system clock
   initial forever #25 CLK_SYS = ~CLK_SYS;
   // hang guard
   always @(posedge CLK_SYS) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         report_and_stop;
      end
   end
   // main sequence
   initial begin
      tick(4);
      RESET_N <= 1'h1;
      tick(2);
      t_reset;
      t_modes;
      t_nav;
      t_push;
      t_notes;
      report_and_stop;
   end
endmodule
bind spc_panel_top spc_panel_chk chk (.*);

// file: bench/spc_player.sv
`timescale 1ns/1ns
module spc_player (
   input  wire logic clk,
   input  wire logic turn,
   input  wire logic turn_up,
   output logic      enc_a,
   output logic      enc_b
);
   logic [3:0] ph = 4'h0;
   logic       b  = 1'h0;
   // track b settles first, a then high two cycles per detent
   always @(posedge clk) begin
      ph <= {ph[2:0], turn};
      if (turn) b <= !turn_up;
   end
   assign enc_a = ph[1] | ph[2];
   assign enc_b = b;
endmodule

// file: hdl/spc_debounce.sv
`timescale 1ns/1ns
module spc_debounce #(
   parameter int CYCLES = 200000
) (
   // clock and reset
   input  wire  logic clk,
   input  wire  logic reset_n,
   // raw and filtered level
   input  wire  logic raw,
   output logic       level,
   output logic       press,
   output logic       release_ev
);
   import spc_pkg::*;

   logic [CNT_W-1:0] cnt;

   // accept a new level only after it held steady for the full time
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt        <= '0;
         level      <= 1'b0;
         press      <= 1'b0;
         release_ev <= 1'b0;
      end else begin
         press      <= 1'b0;
         release_ev <= 1'b0;
         if (raw == level) begin
            cnt <= '0;
         end else if (cnt == CNT_W'(CYCLES - 1)) begin
            cnt        <= '0;
            level      <= raw;
            press      <= raw;
            release_ev <= ~raw;
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end
endmodule

// file: hdl/spc_panel_top.sv
`timescale 1ns/1ns
// Functional notes
// RQ1 - left switch off: usb is virtual serial; on: usb is midi
// RQ2 - right switch off: serial receiver is midi in at fixed rate
// RQ3 - right switch on: serial port is rs232 like usb serial
// RQ4 - unmodified build ignores switches; port1 midi, port2 serial
// RQ5 - up and down keys step the seven themes
// RQ6 - next and back keys cycle items; cursor marks current item
// RQ7 - encoder rotation changes the selected item value
// RQ8 - short push toggles basic and plus; green led shows plus
// RQ9 - push held one second toggles configuration and play mode
// RQ10 - after reset: configuration mode, general theme open
// RQ11 - volume from mute to max boost, default reduced
// RQ12 - sound set index accepted over its full range
// RQ13 - polyphonic by default up to ten voices, mono selectable
// RQ14 - glide acts only on legato notes
// RQ15 - vibrato 0..100 percent, sign picks the slow oscillator
// RQ16 - signed neutral bass sets filter three peak
// RQ17 - signed neutral treble sets filter four peak
// RQ18 - drums from note-on on drum channel, default ten, gm map
// RQ19 - same channel for notes and drums: notes win
// RQ20 - drum level per drum or for all, off up to max boost
// RQ21 - separate stored setup per routing set, switched by item
// RQ22 - keys and encoder switch debounced, one event per press
module spc_panel_top #(
   parameter int LONG_PRESS_CYCLES = spc_pkg::LONG_PRESS_CYC,
   parameter int DEBOUNCE_CYCLES   = spc_pkg::DEBOUNCE_CYC
) (
   // clock and reset
   input  wire  logic                      CLK_SYS,
   input  wire  logic                      RESET_N,
   // panel keys and encoder
   input  wire  logic                      KEY_UP,
   input  wire  logic                      KEY_DOWN,
   input  wire  logic                      NEXT_ITEM_KEY,
   input  wire  logic                      KEY_BACK,
   input  wire  logic                      ENC_PUSH,
   input  wire  logic                      ENC_A,
   input  wire  logic                      ENC_B,
   // communication mode selection
   input  wire  logic                      DIP_LEFT,
   input  wire  logic                      DIP_RIGHT,
   input  wire  logic                      BUILD_UNMODIFIED,
   input  wire  logic                      PANEL_USB_MIDI,
   // incoming note-on events
   input  wire  logic                      NOTE_ON_VALID,
   input  wire  logic [3:0]                NOTE_ON_CH,
   input  wire  logic [6:0]                NOTE_ON_KEY,
   input  wire  logic                      NOTE_LEGATO,
   input  wire  logic [3:0]                CHROMATIC_CH,
   input  wire  logic                      DRUM_CH_WE,
   input  wire  logic [3:0]                DRUM_CH_IN,
   // communication mode outputs
   output logic                            USB_MIDI,
   output logic                            PORT1_RS232,
   output logic [spc_pkg::DIV_W-1:0]       PORT1_BIT_CYC,
   output logic                            PORT2_COM_EN,
   // navigation state
   output spc_pkg::spc_theme_t             THEME,
   output logic [3:0]                      ITEM,
   output logic                            LED_PLUS,
   output logic                            PLAY_MODE,
   output logic                            EXT_STEP,
   output logic                            EXT_UP,
   // general settings
   output logic signed [7:0]               VOLUME,
   output logic [5:0]                      SOUND_SET,
   output logic                            SINGLE_VOICE_STYLE,
   output logic [3:0]                      MAX_VOICES,
   output logic [6:0]                      GLIDE_RATE,
   output logic [6:0]                      VIB_DEPTH,
   output logic                            WOBBLE_FROM_SECOND_OSC,
   output logic signed [7:0]               FILTER3_PEAK,
   output logic signed [7:0]               FILTER4_PEAK,
   output logic                            FLEXIBLE_ROUTING_SET,
   output logic [3:0]                      PERCUSSION_PICK,
   output logic signed [7:0]               DRUM_ALL_LEVEL,
   // note and drum events
   output logic                            NOTE_PLAY,
   output logic                            DRUM_HIT,
   output logic [2:0]                      DRUM_ID,
   output logic signed [7:0]               DRUM_HIT_LEVEL
);
   import spc_pkg::*;

   // ------------------------------------------------------------------
   // functions
   // ------------------------------------------------------------------

   // saturating single step
   function automatic logic signed [7:0] sat_step(
      input logic signed [7:0] v,
      input logic              inc,
      input logic signed [7:0] lo,
      input logic signed [7:0] hi);
      if (inc) begin
         return (v >= hi) ? hi : v + 8'sh01;
      end else begin
         return (v <= lo) ? lo : v - 8'sh01;
      end
   endfunction

   // number of items in a theme level
   function automatic logic [3:0] items_in(
      input spc_theme_t t,
      input logic       p);
      if (t == TH_GENERAL) begin
         return p ? GEN_PLUS_ITEMS : GEN_ITEMS;
      end else if (t == TH_OSC && p) begin
         return OSC_PLUS_ITEMS;
      end else begin
         return OTHER_ITEMS;
      end
   endfunction

   // themes that own a plus level
   function automatic logic has_plus(input spc_theme_t t);
      return (t == TH_GENERAL) || (t == TH_OSC);
   endfunction

   // general midi drum notes, similar types folded in; bit 3 = hit
   function automatic logic [3:0] gm_drum(input logic [6:0] k);
      case (k)
         7'h23, 7'h24:         gm_drum = 4'h8;
         7'h25, 7'h26, 7'h28:  gm_drum = 4'h9;
         7'h2A, 7'h2C:         gm_drum = 4'hA;
         7'h2E:                gm_drum = 4'hB;
         7'h29, 7'h2B, 7'h2D:  gm_drum = 4'hC;
         7'h2F, 7'h30, 7'h32:  gm_drum = 4'hD;
         7'h31, 7'h37, 7'h39:  gm_drum = 4'hE;
         7'h33, 7'h35, 7'h3B:  gm_drum = 4'hF;
         default:              gm_drum = 4'h0;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // key debouncing and encoder
   // ------------------------------------------------------------------
   logic [NKEYS-1:0] raw_key;
   logic [NKEYS-1:0] key_lvl;
   logic [NKEYS-1:0] key_press;
   logic [NKEYS-1:0] key_rel;
   logic             enc_step;
   logic             enc_up;

   assign raw_key = {ENC_PUSH, KEY_BACK, NEXT_ITEM_KEY, KEY_DOWN,
                     KEY_UP};

   // one filter per key
   generate
      for (genvar i = 0; i < NKEYS; i++) begin : g_key
         spc_debounce #(
            .CYCLES     (DEBOUNCE_CYCLES)
         ) u_deb (
            .clk        (CLK_SYS),
            .reset_n    (RESET_N),
            .raw        (raw_key[i]),
            .level      (key_lvl[i]),
            .press      (key_press[i]),   // [RQ22]
            .release_ev (key_rel[i])
         );
      end
   endgenerate

   spc_quad u_quad (
      .clk     (CLK_SYS),
      .reset_n (RESET_N),
      .trk_a   (ENC_A),
      .trk_b   (ENC_B),
      .step    (enc_step),
      .up      (enc_up)
   );

   // ------------------------------------------------------------------
   // communication modes
   // ------------------------------------------------------------------
   logic build_unmod;

   // build strap caught by the clock after reset release
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         build_unmod <= 1'b0;
      end else begin
         build_unmod <= BUILD_UNMODIFIED;
      end
   end

   // route switches or panel choice to the ports
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         USB_MIDI      <= 1'b0;
         PORT1_RS232   <= 1'b0;
         PORT1_BIT_CYC <= MIDI_BIT_CYC;
         PORT2_COM_EN  <= 1'b0;
      end else if (build_unmod) begin
         USB_MIDI      <= PANEL_USB_MIDI;          // [RQ4]
         PORT1_RS232   <= 1'b0;                    // [RQ4]
         PORT1_BIT_CYC <= MIDI_BIT_CYC;
         PORT2_COM_EN  <= 1'b1;                    // [RQ4]
      end else begin
         USB_MIDI      <= DIP_LEFT;                // [RQ1]
         PORT1_RS232   <= DIP_RIGHT;               // [RQ3]
         PORT1_BIT_CYC <= DIP_RIGHT ? COM_BIT_CYC  // [RQ3]
                                    : MIDI_BIT_CYC; // [RQ2]
         PORT2_COM_EN  <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // navigation: theme, item, level, mode
   // ------------------------------------------------------------------
   logic [CNT_W-1:0] hold_cnt;
   logic             hold_used;
   logic [3:0]       n_items;

   assign n_items = items_in(THEME, LED_PLUS);

   // keys and encoder push drive the panel position
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         THEME     <= TH_GENERAL;                   // [RQ10]
         ITEM      <= 4'h0;
         LED_PLUS  <= 1'b0;
         PLAY_MODE <= 1'b0;                         // [RQ10]
         hold_cnt  <= '0;
         hold_used <= 1'b0;
      end else begin
         if (key_press[K_UP]) begin
            THEME    <= (THEME == TH_SYSTEM) ? TH_GENERAL
                        : spc_theme_t'(THEME + 3'h1); // [RQ5]
            ITEM     <= 4'h0;
            LED_PLUS <= 1'b0;
         end else if (key_press[K_DOWN]) begin
            THEME    <= (THEME == TH_GENERAL) ? TH_SYSTEM
                        : spc_theme_t'(THEME - 3'h1); // [RQ5]
            ITEM     <= 4'h0;
            LED_PLUS <= 1'b0;
         end else if (key_press[K_NEXT]) begin
            ITEM <= (ITEM >= n_items - 4'h1) ? 4'h0
                    : ITEM + 4'h1;                  // [RQ6]
         end else if (key_press[K_BACK]) begin
            ITEM <= (ITEM == 4'h0) ? n_items - 4'h1
                    : ITEM - 4'h1;                  // [RQ6]
         end else if (key_rel[K_PUSH] && !hold_used
                      && has_plus(THEME)) begin
            LED_PLUS <= ~LED_PLUS;                  // [RQ8]
            ITEM     <= 4'h0;
         end
         // long hold timer on the filtered push level
         if (key_press[K_PUSH]) begin
            hold_cnt  <= '0;
            hold_used <= 1'b0;
         end else if (key_lvl[K_PUSH] && !hold_used) begin
            if (hold_cnt == CNT_W'(LONG_PRESS_CYCLES - 1)) begin
               PLAY_MODE <= ~PLAY_MODE;             // [RQ9]
               hold_used <= 1'b1;
            end else begin
               hold_cnt <= hold_cnt + 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // general theme values
   // ------------------------------------------------------------------
   logic signed [7:0] vol;
   logic signed [7:0] set_idx;
   logic signed [7:0] glide;
   logic signed [7:0] vib;
   logic signed [7:0] bass [2];
   logic signed [7:0] treb [2];
   logic signed [7:0] dlvl [9];
   logic signed [7:0] pick;
   logic              route;
   logic              mono;
   logic              gen_step;
   logic              plus_step;

   assign gen_step  = enc_step && THEME == TH_GENERAL && !LED_PLUS;
   assign plus_step = enc_step && THEME == TH_GENERAL && LED_PLUS;

   // encoder steps the selected basic item
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         vol     <= VOL_DEF;                        // [RQ11]
         set_idx <= ZERO;
         mono    <= 1'b0;                           // [RQ13]
         glide   <= ZERO;
         vib     <= ZERO;
      end else if (gen_step) begin
         case (ITEM)
            IT_VOL:   vol <= sat_step(vol, enc_up, VOL_MIN,
                                      VOL_MAX);     // [RQ7] [RQ11]
            IT_SET:   set_idx <= sat_step(set_idx, enc_up, ZERO,
                                          SET_MAX); // [RQ12]
            IT_STYLE: mono <= ~mono;                // [RQ13]
            IT_GLIDE: glide <= sat_step(glide, enc_up, ZERO,
                                        GLIDE_MAX);
            IT_VIB:   vib <= sat_step(vib, enc_up, -VIB_LIM,
                                      VIB_LIM);     // [RQ15]
            default:  ;
         endcase
      end
   end

   // tone peaks, kept apart for each routing set
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         bass[0] <= ZERO;                           // [RQ16]
         bass[1] <= ZERO;
         treb[0] <= ZERO;                           // [RQ17]
         treb[1] <= ZERO;
      end else if (gen_step && ITEM == IT_BASS) begin
         bass[route] <= sat_step(bass[route], enc_up, TONE_MIN,
                                 TONE_MAX);         // [RQ16] [RQ21]
      end else if (gen_step && ITEM == IT_TREB) begin
         treb[route] <= sat_step(treb[route], enc_up, TONE_MIN,
                                 TONE_MAX);         // [RQ17] [RQ21]
      end
   end

   // plus level: drum pick, drum level, routing set
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         pick  <= ZERO;
         route <= 1'b0;
         for (int d = 0; d < 9; d++) begin
            dlvl[d] <= ZERO;
         end
      end else if (plus_step) begin
         case (ITEM)
            IT_PICK:  pick <= sat_step(pick, enc_up, ZERO,
                                       PICK_ALL);
            IT_DLVL:  dlvl[pick[3:0]] <= sat_step(dlvl[pick[3:0]],
                         enc_up, DLVL_MIN, DLVL_MAX); // [RQ20]
            IT_ROUTE: route <= ~route;              // [RQ21]
            default:  ;
         endcase
      end
   end

   // steps for themes handled outside this block
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         EXT_STEP <= 1'b0;
         EXT_UP   <= 1'b0;
      end else begin
         EXT_STEP <= enc_step && THEME != TH_GENERAL; // [RQ7]
         EXT_UP   <= enc_up;
      end
   end

   // settings seen outside
   assign VOLUME                 = vol;
   assign SOUND_SET              = set_idx[5:0];
   assign SINGLE_VOICE_STYLE     = mono;
   assign MAX_VOICES             = mono ? VOICES_MONO
                                        : VOICES_POLY; // [RQ13]
   assign VIB_DEPTH              = vib[7] ? 7'(-vib)
                                          : vib[6:0];  // [RQ15]
   assign WOBBLE_FROM_SECOND_OSC = ~vib[7];            // [RQ15]
   assign FILTER3_PEAK           = bass[route];         // [RQ16]
   assign FILTER4_PEAK           = treb[route];         // [RQ17]
   assign FLEXIBLE_ROUTING_SET   = route;
   assign PERCUSSION_PICK        = pick[3:0];
   assign DRUM_ALL_LEVEL         = dlvl[NDRUMS];

   // ------------------------------------------------------------------
   // note and drum dispatch
   // ------------------------------------------------------------------
   logic [3:0] drum_ch;
   logic [3:0] hit;

   assign hit = gm_drum(NOTE_ON_KEY);

   // drum channel setting
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         drum_ch <= DRUM_CH_DEF;                     // [RQ18]
      end else if (DRUM_CH_WE) begin
         drum_ch <= DRUM_CH_IN;                      // [RQ18]
      end
   end

   // music first, then drums; glide latched at note-on
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         NOTE_PLAY      <= 1'b0;
         DRUM_HIT       <= 1'b0;
         DRUM_ID        <= 3'h0;
         DRUM_HIT_LEVEL <= ZERO;
         GLIDE_RATE     <= 7'h00;
      end else begin
         NOTE_PLAY <= 1'b0;
         DRUM_HIT  <= 1'b0;
         if (NOTE_ON_VALID && NOTE_ON_CH == CHROMATIC_CH) begin
            NOTE_PLAY  <= 1'b1;                      // [RQ19]
            GLIDE_RATE <= NOTE_LEGATO ? glide[6:0]
                                      : 7'h00;       // [RQ14]
         end else if (NOTE_ON_VALID && NOTE_ON_CH == drum_ch
                      && hit[3]) begin
            DRUM_HIT       <= 1'b1;                  // [RQ18]
            DRUM_ID        <= hit[2:0];
            DRUM_HIT_LEVEL <= dlvl[{1'b0, hit[2:0]}];  // [RQ20]
         end
      end
   end
endmodule

// file: hdl/spc_pkg.sv
package spc_pkg;

   // ------------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ         = 20_000_000;
   localparam int LONG_PRESS_MS  = 1000;
   localparam int DEBOUNCE_MS    = 10;
   localparam int LONG_PRESS_CYC = CLK_HZ / 1000 * LONG_PRESS_MS;
   localparam int DEBOUNCE_CYC   = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int CNT_W          = 25;

   // serial bit rates, as clock cycles per bit
   localparam int MIDI_BAUD      = 31250;
   localparam int COM_BAUD       = 115200;
   localparam int DIV_W          = 10;
   localparam logic [DIV_W-1:0] MIDI_BIT_CYC =
      DIV_W'(CLK_HZ / MIDI_BAUD);
   localparam logic [DIV_W-1:0] COM_BIT_CYC  =
      DIV_W'((CLK_HZ + COM_BAUD / 2) / COM_BAUD);

   // ------------------------------------------------------------------
   // panel keys
   // ------------------------------------------------------------------
   localparam int NKEYS  = 5;
   localparam int K_UP   = 0;
   localparam int K_DOWN = 1;
   localparam int K_NEXT = 2;
   localparam int K_BACK = 3;
   localparam int K_PUSH = 4;

   // themes in panel order
   typedef enum logic [2:0] {
      TH_GENERAL = 3'h0,
      TH_OSC     = 3'h1,
      TH_ADSR    = 3'h2,
      TH_DELAY   = 3'h3,
      TH_FILTER  = 3'h4,
      TH_ROUTING = 3'h5,
      TH_SYSTEM  = 3'h6
   } spc_theme_t;

   // item counts per level
   localparam logic [3:0] GEN_ITEMS      = 4'h7;
   localparam logic [3:0] GEN_PLUS_ITEMS = 4'h3;
   localparam logic [3:0] OSC_PLUS_ITEMS = 4'h2;
   localparam logic [3:0] OTHER_ITEMS    = 4'h4;

   // general theme items, basic level
   localparam logic [3:0] IT_VOL   = 4'h0;
   localparam logic [3:0] IT_SET   = 4'h1;
   localparam logic [3:0] IT_STYLE = 4'h2;
   localparam logic [3:0] IT_GLIDE = 4'h3;
   localparam logic [3:0] IT_VIB   = 4'h4;
   localparam logic [3:0] IT_BASS  = 4'h5;
   localparam logic [3:0] IT_TREB  = 4'h6;
   // general theme items, plus level
   localparam logic [3:0] IT_PICK  = 4'h0;
   localparam logic [3:0] IT_DLVL  = 4'h1;
   localparam logic [3:0] IT_ROUTE = 4'h2;

   // ------------------------------------------------------------------
   // value ranges and defaults (signed 8 bit, counts and drum channel 4 bit unsigned, dB where levels)
   // ------------------------------------------------------------------
   localparam logic signed [7:0] VOL_MIN   = -8'sh2E;
   localparam logic signed [7:0] VOL_MAX   = 8'sh06;
   localparam logic signed [7:0] VOL_DEF   = -8'sh06;
   localparam logic signed [7:0] SET_MAX   = 8'sh3B;
   localparam logic signed [7:0] GLIDE_MAX = 8'sh63;
   localparam logic signed [7:0] VIB_LIM   = 8'sh64;
   localparam logic signed [7:0] TONE_MIN  = -8'sh40;
   localparam logic signed [7:0] TONE_MAX  = 8'sh3F;
   localparam logic signed [7:0] DLVL_MIN  = -8'sh28;
   localparam logic signed [7:0] DLVL_MAX  = 8'sh0C;
   localparam logic signed [7:0] ZERO      = 8'sh00;
   localparam logic [3:0] NDRUMS           = 4'h8;
   localparam logic signed [7:0] PICK_ALL  = 8'sh08;
   localparam logic [3:0] VOICES_POLY      = 4'hA;
   localparam logic [3:0] VOICES_MONO      = 4'h1;
   localparam logic [3:0] DRUM_CH_DEF      = 4'h9;

endpackage

// file: hdl/spc_quad.sv
`timescale 1ns/1ns
module spc_quad (
   // clock and reset
   input  wire  logic clk,
   input  wire  logic reset_n,
   // encoder tracks
   input  wire  logic trk_a,
   input  wire  logic trk_b,
   // one pulse per detent
   output logic       step,
   output logic       up
);
   logic a_d;

   // a rising edge of track a is a detent, track b gives direction
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         a_d  <= 1'b0;
         step <= 1'b0;
         up   <= 1'b0;
      end else begin
         a_d  <= trk_a;
         step <= trk_a & ~a_d;
         if (trk_a & ~a_d) begin
            up <= ~trk_b;
         end
      end
   end
endmodule
